// ===== dsm_pkg.sv
// Shared constants for the double-rate sample interleaving block.
// Assumes one 125 MHz system clock and 24-bit audio words throughout.
`default_nettype none

package dsm_pkg;

    localparam int CLK_HZ = 125000000;
    localparam int SAMPLE_W = 24;
    localparam int LINK_CH = 8;
    localparam int CH_W = 3;
    localparam int SRC_DS_CH = 4;

    // Base and doubled sample rates
    localparam int RATE_44K1_HZ = 44100;
    localparam int RATE_48K_HZ = 48000;
    localparam int RATE_88K2_HZ = 88200;
    localparam int RATE_96K_HZ = 96000;
    localparam int MAX_LINK_RATE_HZ = 48000;

    // Phase accumulator increments, rate * 2^32 / clock
    localparam int ACC_W = 32;
    localparam logic [ACC_W-1:0] INC_44K1 =
        ACC_W'((64'(RATE_44K1_HZ) << ACC_W) / 64'(CLK_HZ));
    localparam logic [ACC_W-1:0] INC_48K =
        ACC_W'((64'(RATE_48K_HZ) << ACC_W) / 64'(CLK_HZ));
    localparam logic [ACC_W-1:0] INC_88K2 =
        ACC_W'((64'(RATE_88K2_HZ) << ACC_W) / 64'(CLK_HZ));
    localparam logic [ACC_W-1:0] INC_96K =
        ACC_W'((64'(RATE_96K_HZ) << ACC_W) / 64'(CLK_HZ));

    // Shortest legal link frame, rounded down to whole cycles
    localparam int FRAME_MIN_CYC = CLK_HZ / MAX_LINK_RATE_HZ;
    localparam int GAP_W = 13;

    // Pass-through delay in frame periods and bank ring
    localparam int LAT_FRAMES = 3;
    localparam int BANKS = 4;
    localparam int BANK_W = 2;

    // Playback safety margin in samples
    localparam int SAFETY_SAMPLES = 32;
    localparam int HOSTBUF_W = 12;
    localparam int WAIT_W = 13;

    // Transmit buffer
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W = CH_W + SAMPLE_W;

    // Transfer checking
    localparam int SEQ_W = 8;
    localparam int LEN_W = 8;
    localparam int POS_W = 32;
    localparam int ERRCNT_W = 16;
    localparam logic DIR_REC = 1'b0;
    localparam logic DIR_PLAY = 1'b1;

endpackage

`default_nettype wire

// ===== dsm_rate_gen.sv
// Fractional sample-tick generator driven by a phase accumulator.
// Assumes the increment is held steady by the caller between frames.
`timescale 1ns/1ps
`default_nettype none

module dsm_rate_gen
    import dsm_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic sys_rst, // Async reset, active high
    input wire logic [ACC_W-1:0] inc, // Phase step per clock
    output logic tick // One pulse per sample period
);

    logic [ACC_W-1:0] acc;
    logic [ACC_W:0] next_sum;

    assign next_sum = {1'b0, acc} + {1'b0, inc};

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc <= '0;
            tick <= 1'b0;
        end else begin
            acc <= next_sum[ACC_W-1:0];
            tick <= next_sum[ACC_W];
        end
    end

endmodule // dsm_rate_gen

`default_nettype wire

// ===== dsm_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock; full and empty come from an occupancy count.
`timescale 1ns/1ps
`default_nettype none

module dsm_fifo #(
    parameter int WIDTH = 27,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk, // System clock
    input wire logic sys_rst, // Async reset, active high
    input wire logic in_valid, // Write request
    output logic in_ready, // Not full
    input wire logic [WIDTH-1:0] in_data, // Write word
    output logic out_valid, // Not empty
    input wire logic out_ready, // Read accept
    output logic [WIDTH-1:0] out_data // Head word
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule // dsm_fifo

`default_nettype wire

// ===== dsm_top.sv
// Double-rate sample interleaving onto an 8-channel optical link,
// with pass-through delay, playback safety wait and transfer checking.
// Assumes mixer and transfer engine run on sys_clk; mode pins do not.
`timescale 1ns/1ps
`default_nettype none

module dsm_top
    import dsm_pkg::*;
(
    input wire logic sys_clk, // 125 MHz system clock
    input wire logic sys_rst, // Async reset, active high
    input wire logic rate_48k_pin, // Base rate: 1 = 48k, 0 = 44.1k
    input wire logic double_rate_operation, // Double rate request pin
    output logic smp_tick, // Internal sample period pulse
    output logic sample_interleaving, // Link is interleaving
    input wire logic mix_valid, // Mixer sample valid
    output logic mix_ready, // Mixer sample accepted
    input wire logic [CH_W-1:0] mix_chan, // Mixer source channel
    input wire logic [SAMPLE_W-1:0] mix_sample, // Mixer sample
    output logic tx_valid, // Link word valid
    input wire logic tx_ready, // Transmitter takes word
    output logic [CH_W-1:0] tx_chan, // Link channel of word
    output logic [SAMPLE_W-1:0] tx_sample, // Link sample word
    output logic tx_frame, // Link frame start pulse
    output logic tx_overrun, // Sticky: frame not drained in time
    input wire logic [HOSTBUF_W-1:0] host_buf_size, // Host buffer, samples
    input wire logic play_start, // Host stream start pulse
    input wire logic play_stop, // Host stream stop pulse
    output logic play_run, // Playback released
    input wire logic usb_pkt_valid, // Transfer packet done pulse
    input wire logic usb_pkt_dir, // 0 record, 1 playback
    input wire logic usb_pkt_bad, // Packet failed its check
    input wire logic [SEQ_W-1:0] usb_pkt_seq, // Packet sequence number
    input wire logic [LEN_W-1:0] usb_pkt_len, // Samples per packet
    input wire logic err_clr, // Clear sticky transfer error flags
    output logic rec_err, // Sticky record transfer error
    output logic play_err, // Sticky playback transfer error
    output logic [ERRCNT_W-1:0] err_count, // Total transfer errors
    output logic [POS_W-1:0] rec_pos, // Record sample position
    output logic [POS_W-1:0] play_pos // Playback sample position
);

    typedef enum logic [1:0] {
        DSM_IDLE = 2'b00,
        DSM_SEND = 2'b01
    } dsm_send_t;

    // Link slot: keep flag plus link channel
    function automatic logic [CH_W:0] link_slot(
        input logic [CH_W-1:0] chan,
        input logic dbl,
        input logic ph
    );
        if (!dbl) begin
            link_slot = {1'b1, chan};
        end else if (chan < CH_W'(SRC_DS_CH)) begin
            link_slot = {1'b1, chan[1:0], ph};
        end else begin
            link_slot = {1'b0, CH_W'(0)};
        end
    endfunction

    // Position advance across a gap of missed packets
    function automatic logic [POS_W-1:0] pos_step(
        input logic [SEQ_W-1:0] gap,
        input logic [LEN_W-1:0] len
    );
        pos_step = POS_W'(gap) * POS_W'(len) + POS_W'(len);
    endfunction

    logic [1:0] rate_sync;
    logic [1:0] dbl_sync;
    logic mode_dbl;
    logic mode_48k;
    logic [ACC_W-1:0] smp_inc;
    logic phase;
    logic frame_tick;
    logic [SAMPLE_W-1:0] bank [BANKS][LINK_CH];
    logic [BANK_W-1:0] wr_bank;
    logic [BANK_W-1:0] send_bank;
    logic [CH_W-1:0] send_idx;
    dsm_send_t send_state;
    logic [CH_W:0] slot;
    logic mix_take;
    logic fifo_in_ready;
    logic push;
    logic [FIFO_W-1:0] fifo_out;
    logic [WAIT_W-1:0] play_wait;
    logic play_armed;
    logic [SEQ_W-1:0] rec_seq;
    logic [SEQ_W-1:0] play_seq;
    logic [SEQ_W-1:0] gap;
    logic seq_err;
    logic pkt_err;
    logic [GAP_W-1:0] frame_gap;
    logic [1:0] ticks_in_frame;

    // Mode pins come from another domain
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rate_sync <= 2'b00;
            dbl_sync <= 2'b00;
        end else begin
            rate_sync <= {rate_sync[0], rate_48k_pin};
            dbl_sync <= {dbl_sync[0], double_rate_operation};
        end
    end

    // Mode changes only at a frame boundary
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_dbl <= 1'b0;
            mode_48k <= 1'b0;
        end else if (frame_tick) begin
            mode_dbl <= dbl_sync[1];
            mode_48k <= rate_sync[1];
        end
    end

    always_comb begin
        unique case ({mode_dbl, mode_48k})
            2'b00: smp_inc = INC_44K1;
            2'b01: smp_inc = INC_48K;
            2'b10: smp_inc = INC_88K2;
            2'b11: smp_inc = INC_96K;
        endcase
    end

    dsm_rate_gen u_rate (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .inc(smp_inc),
        .tick(smp_tick)
    );

    // Every second tick closes a frame at double rate
    assign frame_tick = smp_tick && (!mode_dbl || phase);
    assign sample_interleaving = mode_dbl;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase <= 1'b0;
        end else if (frame_tick) begin
            phase <= 1'b0;
        end else if (smp_tick) begin
            phase <= 1'b1;
        end
    end

    // Mixer side: always accepts, upper channels dropped at double rate
    assign mix_ready = 1'b1;
    assign mix_take = mix_valid && mix_ready;
    assign slot = link_slot(mix_chan, mode_dbl, phase);

    always_ff @(posedge sys_clk) begin
        if (mix_take && slot[CH_W]) begin
            bank[wr_bank][slot[CH_W-1:0]] <= mix_sample;
        end
    end

    // Bank ring: frame n leaves at the third frame tick
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_bank <= '0;
        end else if (frame_tick) begin
            wr_bank <= wr_bank + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            send_state <= DSM_IDLE;
            send_bank <= '0;
            send_idx <= '0;
        end else if (frame_tick) begin
            send_state <= DSM_SEND;
            send_bank <= wr_bank - BANK_W'(LAT_FRAMES - 1);
            send_idx <= '0;
        end else if (push) begin
            send_idx <= send_idx + 1'b1;
            if (send_idx == CH_W'(LINK_CH - 1)) begin
                send_state <= DSM_IDLE;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_overrun <= 1'b0;
        end else if (frame_tick && send_state == DSM_SEND) begin
            tx_overrun <= 1'b1;
        end
    end

    // Full buffer stalls the frame sender
    assign push = (send_state == DSM_SEND) && fifo_in_ready;

    dsm_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_valid(send_state == DSM_SEND),
        .in_ready(fifo_in_ready),
        .in_data({send_idx, bank[send_bank][send_idx]}),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(fifo_out)
    );

    assign tx_chan = fifo_out[FIFO_W-1:SAMPLE_W];
    assign tx_sample = fifo_out[SAMPLE_W-1:0];
    assign tx_frame = tx_valid && tx_ready && (tx_chan == '0);

    // Playback waits host buffer plus the safety margin
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            play_wait <= '0;
            play_armed <= 1'b0;
            play_run <= 1'b0;
        end else if (play_stop) begin
            play_armed <= 1'b0;
            play_run <= 1'b0;
        end else if (play_start) begin
            play_wait <= WAIT_W'(host_buf_size) +
                WAIT_W'(SAFETY_SAMPLES);
            play_armed <= 1'b1;
            play_run <= 1'b0;
        end else if (play_armed && smp_tick) begin
            if (play_wait == '0) begin
                play_armed <= 1'b0;
                play_run <= 1'b1;
            end else begin
                play_wait <= play_wait - 1'b1;
            end
        end
    end

    // Transfer checking and drop-out repositioning
    assign gap = usb_pkt_seq - (usb_pkt_dir ? play_seq : rec_seq);
    assign seq_err = (gap != '0);
    assign pkt_err = usb_pkt_valid && (usb_pkt_bad || seq_err);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rec_seq <= '0;
            play_seq <= '0;
            rec_pos <= '0;
            play_pos <= '0;
        end else if (usb_pkt_valid) begin
            if (usb_pkt_dir == DIR_PLAY) begin
                play_seq <= usb_pkt_seq + 1'b1;
                play_pos <= play_pos + pos_step(gap, usb_pkt_len);
            end else begin
                rec_seq <= usb_pkt_seq + 1'b1;
                rec_pos <= rec_pos + pos_step(gap, usb_pkt_len);
            end
        end
    end

    // Set wins over clear
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rec_err <= 1'b0;
            play_err <= 1'b0;
        end else begin
            rec_err <= (rec_err && !err_clr) ||
                (pkt_err && usb_pkt_dir == DIR_REC);
            play_err <= (play_err && !err_clr) ||
                (pkt_err && usb_pkt_dir == DIR_PLAY);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            err_count <= '0;
        end else if (pkt_err && err_count != '1) begin
            err_count <= err_count + 1'b1;
        end
    end

    // Helper counters for checking frame timing
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            frame_gap <= '0;
            ticks_in_frame <= '0;
        end else if (frame_tick) begin
            frame_gap <= '0;
            ticks_in_frame <= '0;
        end else begin
            if (frame_gap != '1) begin
                frame_gap <= frame_gap + 1'b1;
            end
            if (smp_tick) begin
                ticks_in_frame <= ticks_in_frame + 1'b1;
            end
        end
    end

    chk_rate_select: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        mode_dbl |-> smp_inc == (mode_48k ? INC_96K : INC_88K2))
        else $error("double rate increment wrong");

    chk_sample_width: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (mix_take && !mode_dbl) |=>
        bank[$past(wr_bank)][$past(mix_chan)] == $past(mix_sample))
        else $error("sample not stored intact");

    chk_odd_even: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (mix_take && mode_dbl && mix_chan < CH_W'(SRC_DS_CH)) |=>
        bank[$past(wr_bank)][{$past(mix_chan[1:0]), $past(phase)}]
            == $past(mix_sample))
        else $error("interleaved sample misplaced");

    chk_link_rate: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        frame_tick |->
        frame_gap >= GAP_W'(FRAME_MIN_CYC - 1))
        else $error("link frame faster than 48 kHz");

    chk_upper_drop: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (mode_dbl && mix_chan >= CH_W'(SRC_DS_CH)) |-> !slot[CH_W])
        else $error("upper channel kept at double rate");

    chk_frame_ticks: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (frame_tick && mode_dbl) |-> ticks_in_frame == 2'd1)
        else $error("double rate frame not two samples");

    chk_delay_bank: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        frame_tick |=> send_bank ==
            $past(wr_bank) - BANK_W'(LAT_FRAMES - 1)
            && send_state == DSM_SEND)
        else $error("pass-through delay wrong");

    chk_safety_load: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (play_start && !play_stop) |=> play_wait ==
            WAIT_W'($past(host_buf_size)) + WAIT_W'(SAFETY_SAMPLES)
            && !play_run)
        else $error("safety wait not loaded");

    chk_usb_flag: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (usb_pkt_valid && usb_pkt_bad && usb_pkt_dir == DIR_REC) |=>
        rec_err && ($changed(err_count) || err_count == '1))
        else $error("record error not flagged");

    cov_double_frame: cover property (
        @(posedge sys_clk) disable iff (sys_rst) frame_tick && mode_dbl);
    cov_overrun: cover property (
        @(posedge sys_clk) disable iff (sys_rst) $rose(tx_overrun));
    cov_usb_gap: cover property (
        @(posedge sys_clk) disable iff (sys_rst) usb_pkt_valid && seq_err);
    cov_play_run: cover property (
        @(posedge sys_clk) disable iff (sys_rst) $rose(play_run));

endmodule // dsm_top

`default_nettype wire

// ===== dsm_link_rx.sv
// Model of the remote optical receiver at the far end of the link.
// Assumes the link words are offered on sys_clk with valid/ready.
`timescale 1ns/1ps
`default_nettype none

module dsm_link_rx (
    input wire logic sys_clk, // System clock
    input wire logic slow, // Stall at random when high
    output logic tx_ready // Word accepted
);
    integer seed = 32'hbbb5ecbb;

    initial tx_ready = 1'b1;

    // Takes a word on every clock, or on about three clocks in four when slow
    always @(posedge sys_clk) begin
        #1 tx_ready <= slow ? (($random(seed) & 3) != 0) : 1'b1;
    end
endmodule // dsm_link_rx

`default_nettype wire

// ===== double_speed_sample_mux_tb.sv
// Self-checking bench for the double-rate interleaving block.
// Assumes the receiver model answers the link handshake.
`timescale 1ns/1ps
`default_nettype none

module double_speed_sample_mux_tb;
    import dsm_pkg::*;
    typedef struct {
        logic [CH_W-1:0] c;
        logic [SAMPLE_W-1:0] s;
        int f;
    } dsm_exp_t;
    logic sys_clk = 0, sys_rst = 1, rate_48k_pin = 0;
    logic double_rate_operation = 0, mix_valid = 0, play_start = 0;
    logic play_stop = 0, usb_pkt_valid = 0, usb_pkt_dir = 0;
    logic usb_pkt_bad = 0, err_clr = 0, slow = 0;
    logic [CH_W-1:0] mix_chan = '0;
    logic [SAMPLE_W-1:0] mix_sample = '0;
    logic [HOSTBUF_W-1:0] host_buf_size = '0;
    logic [SEQ_W-1:0] usb_pkt_seq = '0;
    logic [LEN_W-1:0] usb_pkt_len = '0;
    logic smp_tick, sample_interleaving, mix_ready, tx_valid, tx_ready;
    logic tx_frame, tx_overrun, play_run, rec_err, play_err;
    logic [CH_W-1:0] tx_chan;
    logic [SAMPLE_W-1:0] tx_sample;
    logic [ERRCNT_W-1:0] err_count;
    logic [POS_W-1:0] rec_pos, play_pos;
    int failures = 0, checked = 0, nfr = 0, gap = 0, nt = 0, per = 1;
    integer seed = 32'hbbb5ecbb;
    dsm_exp_t q[$];
    dsm_exp_t e;

    always #4 sys_clk = ~sys_clk;

    dsm_top dsm_top_inst (.sys_clk, .sys_rst, .rate_48k_pin,
        .double_rate_operation, .smp_tick, .sample_interleaving,
        .mix_valid, .mix_ready, .mix_chan, .mix_sample, .tx_valid,
        .tx_ready, .tx_chan, .tx_sample, .tx_frame, .tx_overrun,
        .host_buf_size, .play_start, .play_stop, .play_run,
        .usb_pkt_valid, .usb_pkt_dir, .usb_pkt_bad, .usb_pkt_seq,
        .usb_pkt_len, .err_clr, .rec_err, .play_err, .err_count,
        .rec_pos, .play_pos);

    dsm_link_rx dsm_link_rx_inst (.sys_clk, .slow, .tx_ready);

    task automatic chk(string n, logic [31:0] ex, logic [31:0] got);
        checked++;
        if (got !== ex) begin
            failures++;
            $display("Error %s expected %h seen %h", n, ex, got);
        end
    endtask

    task automatic test_done;
        if (failures == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Tick spacing and link words against the oldest note
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            nfr = 0;
            nt = 0;
            gap = 0;
        end else begin
            gap++;
            if (smp_tick === 1'b1) begin
                if (nt >= 2)
                    chk("tick_gap", 1, gap >= per && gap <= per + 1);
                nt++;
                gap = 0;
            end
            if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
                if (tx_frame === 1'b1)
                    nfr++;
                if (q.size() > 0 && nfr >= q[0].f) begin
                    e = q.pop_front();
                    chk("tx_chan", e.c, tx_chan);
                    chk("tx_sample", e.s, tx_sample);
                end
            end
        end
    end

    // Next sample tick, then whether a link frame followed it
    task automatic wait_tick(output logic fr);
        int k, n0;
        k = 0;
        do begin
            @(posedge sys_clk);
            #1;
            k++;
        end while (smp_tick !== 1'b1 && k < 3000);
        if (k >= 3000) begin
            chk("tick_wait", 0, 1);
            test_done;
        end
        n0 = nfr;
        for (k = 0; k < 60 && nfr == n0; k++) begin
            @(posedge sys_clk);
            #1;
        end
        fr = nfr != n0;
    endtask

    task automatic write_all(output logic [SAMPLE_W-1:0] v [8]);
        for (int c = 0; c < 8; c++) begin
            v[c] = {4'ha, 20'($random(seed))};
            mix_valid = 1;
            mix_chan = CH_W'(c);
            mix_sample = v[c];
            @(posedge sys_clk);
            #1;
        end
        mix_valid = 0;
    endtask

    task automatic run_mode(input logic r48, d, input int nf, input logic s);
        logic fr;
        logic [SAMPLE_W-1:0] ev [8], od [8];
        int f, g, fn;
        sys_rst = 1;
        rate_48k_pin = r48;
        double_rate_operation = d;
        slow = s;
        per = CLK_HZ / (d ? (r48 ? RATE_96K_HZ : RATE_88K2_HZ)
            : (r48 ? RATE_48K_HZ : RATE_44K1_HZ));
        repeat (8) @(posedge sys_clk);
        #1 sys_rst = 0;
        repeat (3) wait_tick(fr);
        chk("interleave", d, sample_interleaving);
        chk("mix_ready", 1, mix_ready);
        f = 0;
        g = 0;
        while (f < nf && g < 4 * nf + 8) begin
            g++;
            wait_tick(fr);
            if (!d)
                chk("link_frame", 1, fr);
            if (d && !fr)
                continue;
            fn = nfr + 3;
            write_all(ev);
            if (d) begin
                wait_tick(fr);
                chk("link_frame", 0, fr);
                write_all(od);
                for (int c = 0; c < 4; c++) begin
                    q.push_back('{CH_W'(2 * c), ev[c], fn});
                    q.push_back('{CH_W'(2 * c + 1), od[c], fn});
                end
            end else begin
                for (int c = 0; c < 8; c++)
                    q.push_back('{CH_W'(c), ev[c], fn});
            end
            f++;
        end
        chk("frames", nf, f);
        for (g = 0; g < 20000 && q.size() > 0; g++)
            @(posedge sys_clk);
        #1;
        chk("tx_left", 0, q.size());
        chk("tx_overrun", 0, tx_overrun);
        if (f < nf || q.size() > 0)
            test_done;
    endtask

    task automatic pkt(input logic dir, bad, input logic [7:0] s, l);
        usb_pkt_valid = 1;
        usb_pkt_dir = dir;
        usb_pkt_bad = bad;
        usb_pkt_seq = s;
        usb_pkt_len = l;
        @(posedge sys_clk);
        #1 usb_pkt_valid = 0;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic usb_play;
        logic fr;
        logic [LEN_W-1:0] l;
        l = LEN_W'(($random(seed) & 63) + 1);
        pkt(0, 0, 0, l);
        chk("rec_err", 0, rec_err);
        chk("rec_pos", 32'(l), rec_pos);
        pkt(0, 1, 1, l);
        chk("rec_err", 1, rec_err);
        pkt(1, 0, 0, l);
        pkt(1, 0, 3, l);
        chk("play_err", 1, play_err);
        chk("err_count", 2, err_count);
        chk("play_pos", 32'(l) * 4, play_pos);
        err_clr = 1;
        @(posedge sys_clk);
        #1 err_clr = 0;
        @(posedge sys_clk);
        #1;
        chk("rec_err", 0, rec_err);
        chk("play_err", 0, play_err);
        // Zero host buffer leaves only the fixed margin
        // Start well clear of a sample tick so none is missed
        wait_tick(fr);
        play_start = 1;
        @(posedge sys_clk);
        #1 play_start = 0;
        for (int i = 1; i <= 34; i++) begin
            wait_tick(fr);
            chk("play_run", i >= 33, play_run);
        end
        play_stop = 1;
        @(posedge sys_clk);
        #1 play_stop = 0;
        @(posedge sys_clk);
        #1;
        chk("play_run", 0, play_run);
    endtask

    initial begin
        run_mode(0, 0, 1, 0);
        run_mode(0, 1, 2, 1);
        run_mode(1, 0, 0, 0);
        run_mode(1, 1, 0, 0);
        usb_play();
        test_done;
    end
endmodule // double_speed_sample_mux_tb

`default_nettype wire
